/* File: fcpe_flow_power_regs.sv */
// flow control state word and power event driver flags behind an ahb-lite slave
// Behaviour
// - pause-low flag set by nonzero low pause
// - paused flag set by nonzero pause, timer clears
// - full flag set on pause sent, clears on exit
// - writing xoff raises internal xoff request
// - xoff bit reads pending request from either source
// - writing xon clears request; xon reads zero
// - send pause when free space hits threshold
// - threshold codes 0.5K, 1K, then 0.25K steps
// - link change flag, write one clears
// - wake pattern flag, set regardless of enables
// - interesting frame flag, write one clears
// - driver ready bit drives management ready output
// - busy bit shows management traffic in progress
// - wake status mirror, one clears it and output
// - power event flags reset by alternate reset only
// - bits 26 and 28 read only, reset zero
//
// Register access over AHB-Lite is this design's own decision.
`default_nettype none
module fcpe_flow_power_regs #(
  parameter int FREE_W = 16,
  parameter int PAUSE_VAL_W = 16,
  parameter bit WAKE_CLEARABLE = 1'b1
) (
  // clock and resets
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic ALT_RST_IN,
  // ahb-lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // receive side flow control events
  input wire logic RX_PAUSE_IN,
  input wire logic RX_PAUSE_LOW_IN,
  input wire logic [PAUSE_VAL_W-1:0] RX_PAUSE_VALUE_IN,
  input wire logic PAUSE_TIMER_ZERO_IN,
  input wire logic [FREE_W-1:0] RX_FIFO_FREE_IN,
  input wire logic DESC_PAUSE_REQ_IN,
  // pause frame transmit handshake
  output logic PAUSE_SEND_OUT,
  input wire logic PAUSE_SENT_IN,
  // wake and frame filter events
  input wire logic WAKE_PATTERN_IN,
  input wire logic INTERESTING_FRAME_IN,
  input wire logic WAKE_EVENT_IN,
  output logic WAKE_STATUS_OUT,
  output logic WAKE_EVENT_N_OUT,
  // pins
  input wire logic LINK_UP_IN,
  input wire logic MGMT_BUSY_IN,
  input wire logic MGMT_FORCE_IN,
  output logic MGMT_READY_OUT,
  // interrupt
  output logic IRQ_OUT
);
  import fcpe_pkg::*;

  // threshold code to free bytes
  function automatic logic [15:0] thr_bytes(input logic [2:0] code);
    logic [15:0] r;
    r = FCPE_THR_BASE0;
    if (code != 3'h0) begin
      r = 16'(FCPE_THR_BASE1 + 16'(code - 3'h1) * FCPE_THR_STEP);
    end
    return r;
  endfunction

  // pin synchronisers: stage one is read only by stage two
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic link_prev_reg;
  logic link_up_sync;
  logic mgmt_busy_sync;
  logic mgmt_force_sync;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      pin_s1_reg <= 3'h0;
      pin_s2_reg <= 3'h0;
    end else begin
      pin_s1_reg <= {MGMT_FORCE_IN, MGMT_BUSY_IN, LINK_UP_IN};
      pin_s2_reg <= pin_s1_reg;
    end
  end

  assign link_up_sync = pin_s2_reg[0];
  assign mgmt_busy_sync = pin_s2_reg[1];
  assign mgmt_force_sync = pin_s2_reg[2];

  // no change until sync stages and previous level refill; a bus reset would fake one
  logic [2:0] link_fill_reg;
  logic link_change;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      link_prev_reg <= 1'b0;
      link_fill_reg <= 3'h0;
    end else begin
      link_prev_reg <= link_up_sync;
      link_fill_reg <= {link_fill_reg[1:0], 1'b1};
    end
  end

  assign link_change = link_fill_reg[2] && (link_up_sync != link_prev_reg);

  // ahb address phase capture
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_ctrl;
  logic wr_mask;

  assign addr_ok = HSEL_IN && HREADY_IN && (HTRANS_IN == FCPE_HTRANS_NONSEQ);

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE_IN;
      wr_addr_reg <= HADDR_IN[7:0];
    end
  end

  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == FCPE_OFS_CTRL);
  assign wr_mask = wr_pend_reg && (wr_addr_reg == FCPE_OFS_IRQ_MASK);

  // zero wait state slave, always okay
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      HREADYOUT_OUT <= 1'b0;
      HRESP_OUT <= FCPE_HRESP_OKAY;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= FCPE_HRESP_OKAY;
    end
  end

  // xoff request from a software write or the descriptor pause request
  logic xoff_reg;
  logic xoff_set;
  logic xon_clr;

  assign xoff_set = (wr_ctrl && HWDATA_IN[FCPE_BIT_XOFF]) || DESC_PAUSE_REQ_IN;
  assign xon_clr = wr_ctrl && HWDATA_IN[FCPE_BIT_XON];

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      xoff_reg <= 1'b0;
    end else if (xoff_set) begin
      xoff_reg <= 1'b1;
    end else if (xon_clr) begin
      xoff_reg <= 1'b0;
    end
  end

  // threshold field, reserved neighbours are not stored
  logic [2:0] thr_reg;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      thr_reg <= FCPE_THR_RST;
    end else if (wr_ctrl) begin
      thr_reg <= HWDATA_IN[FCPE_THR_MSB:FCPE_THR_LSB];
    end
  end

  // pause cause: buffer nearly full or xoff pending
  logic at_thr;
  logic pause_cause;
  assign at_thr = 32'(RX_FIFO_FREE_IN) <= 32'(thr_bytes(thr_reg));
  assign pause_cause = at_thr || xoff_reg;

  // request a pause frame once per entry into the full state
  fcpe_fc_state_t fc_state_reg;
  fcpe_fc_state_t fc_state_next;

  always_comb begin
    fc_state_next = fc_state_reg;
    case (fc_state_reg)
      FCPE_FC_IDLE: begin
        if (pause_cause) begin
          fc_state_next = FCPE_FC_REQ;
        end
      end
      FCPE_FC_REQ: begin
        if (PAUSE_SENT_IN) begin
          fc_state_next = FCPE_FC_FULL;
        end else if (!pause_cause) begin
          fc_state_next = FCPE_FC_IDLE;
        end
      end
      FCPE_FC_FULL: begin
        if (!pause_cause) begin
          fc_state_next = FCPE_FC_IDLE;
        end
      end
      default: begin
        fc_state_next = FCPE_FC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      fc_state_reg <= FCPE_FC_IDLE;
    end else begin
      fc_state_reg <= fc_state_next;
    end
  end

  // level request held until the transmitter reports the frame sent or the pause cause goes away
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PAUSE_SEND_OUT <= 1'b0;
    end else begin
      PAUSE_SEND_OUT <= (fc_state_next == FCPE_FC_REQ);
    end
  end

  // received pause state flags
  logic paused_reg;
  logic paused_low_reg;
  logic pause_nz;
  logic paused_set;
  logic paused_low_set;

  assign pause_nz = RX_PAUSE_VALUE_IN != '0;
  assign paused_set = RX_PAUSE_IN && !RX_PAUSE_LOW_IN && pause_nz;
  assign paused_low_set = RX_PAUSE_IN && RX_PAUSE_LOW_IN && pause_nz;

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      paused_reg <= 1'b0;
    end else if (paused_set) begin
      paused_reg <= 1'b1;
    end else if (PAUSE_TIMER_ZERO_IN) begin
      paused_reg <= 1'b0;
    end
  end

  // any other pause frame ends the low state; a new nonzero low pause wins
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      paused_low_reg <= 1'b0;
    end else if (paused_low_set) begin
      paused_low_reg <= 1'b1;
    end else if (PAUSE_TIMER_ZERO_IN || RX_PAUSE_IN) begin
      paused_low_reg <= 1'b0;
    end
  end

  // power event driver flags, kept over a bus reset
  logic link_chg_reg;
  logic wake_pat_reg;
  logic interest_reg;
  logic mgmt_rdy_reg;
  logic wake_stat_reg;
  logic w1c_link;
  logic w1c_pat;
  logic w1c_int;
  logic w1c_wake;

  assign w1c_link = wr_ctrl && HWDATA_IN[FCPE_BIT_LINK_CHG];
  assign w1c_pat = wr_ctrl && HWDATA_IN[FCPE_BIT_WAKE_PAT];
  assign w1c_int = wr_ctrl && HWDATA_IN[FCPE_BIT_INTEREST];
  assign w1c_wake = wr_ctrl && HWDATA_IN[FCPE_BIT_WAKE_STAT] && WAKE_CLEARABLE;

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge CLK_IN) begin
    if (ALT_RST_IN) begin
      link_chg_reg <= FCPE_PWR_FLAGS_RST[FCPE_BIT_LINK_CHG-24];
      wake_pat_reg <= FCPE_PWR_FLAGS_RST[FCPE_BIT_WAKE_PAT-24];
      interest_reg <= FCPE_PWR_FLAGS_RST[FCPE_BIT_INTEREST-24];
      mgmt_rdy_reg <= FCPE_PWR_FLAGS_RST[FCPE_BIT_MGMT_RDY-24];
      wake_stat_reg <= FCPE_PWR_FLAGS_RST[FCPE_BIT_WAKE_STAT-24];
    end else begin
      link_chg_reg <= link_change || (link_chg_reg && !w1c_link);
      wake_pat_reg <= WAKE_PATTERN_IN || (wake_pat_reg && !w1c_pat);
      interest_reg <= INTERESTING_FRAME_IN || (interest_reg && !w1c_int);
      wake_stat_reg <= WAKE_EVENT_IN || (wake_stat_reg && !w1c_wake);
      if (wr_ctrl) begin
        mgmt_rdy_reg <= HWDATA_IN[FCPE_BIT_MGMT_RDY];
      end
    end
  end

  // outputs that follow the power event flags
  always_ff @(posedge CLK_IN) begin
    if (ALT_RST_IN) begin
      MGMT_READY_OUT <= 1'b0;
      WAKE_STATUS_OUT <= 1'b0;
      WAKE_EVENT_N_OUT <= 1'b1;
    end else begin
      MGMT_READY_OUT <= mgmt_rdy_reg;
      WAKE_STATUS_OUT <= wake_stat_reg;
      WAKE_EVENT_N_OUT <= !wake_stat_reg;
    end
  end

  // read view of the shared word
  logic [31:0] ctrl_word;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[FCPE_BIT_PAUSED_LOW] = paused_low_reg;
    ctrl_word[FCPE_BIT_PAUSED] = paused_reg;
    ctrl_word[FCPE_BIT_FULL] = (fc_state_reg == FCPE_FC_FULL);
    ctrl_word[FCPE_BIT_XOFF] = xoff_reg;
    ctrl_word[FCPE_BIT_XON] = 1'b0;
    ctrl_word[FCPE_THR_MSB:FCPE_THR_LSB] = thr_reg;
    ctrl_word[FCPE_BIT_LINK_CHG] = link_chg_reg;
    ctrl_word[FCPE_BIT_WAKE_PAT] = wake_pat_reg;
    ctrl_word[FCPE_BIT_INTEREST] = interest_reg;
    ctrl_word[FCPE_BIT_RSVD28] = 1'b0;
    ctrl_word[FCPE_BIT_MGMT_RDY] = mgmt_rdy_reg;
    ctrl_word[FCPE_BIT_MGMT_FORCE] = mgmt_force_sync;
    ctrl_word[FCPE_BIT_MGMT_BUSY] = mgmt_busy_sync;
    ctrl_word[FCPE_BIT_WAKE_STAT] = wake_stat_reg;
  end

  // interrupt status, mask and read-to-clear
  logic [FCPE_IRQ_W-1:0] irq_stat_reg;
  logic [FCPE_IRQ_W-1:0] irq_mask_reg;
  logic [FCPE_IRQ_W-1:0] irq_event;
  logic rd_stat;

  assign rd_stat = addr_ok && !HWRITE_IN && (HADDR_IN[7:0] == FCPE_OFS_IRQ_STAT);

  always_comb begin
    irq_event = '0;
    irq_event[FCPE_IRQ_LINK] = link_change;
    irq_event[FCPE_IRQ_WAKE_PAT] = WAKE_PATTERN_IN;
    irq_event[FCPE_IRQ_INTEREST] = INTERESTING_FRAME_IN;
    irq_event[FCPE_IRQ_WAKE] = WAKE_EVENT_IN;
    irq_event[FCPE_IRQ_PAUSED] = paused_set || paused_low_set;
    irq_event[FCPE_IRQ_SENT] = (fc_state_reg == FCPE_FC_REQ) && PAUSE_SENT_IN;
  end

  // an event in the clearing read's cycle stays pending for the next read
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_stat_reg <= FCPE_IRQ_RST;
    end else if (rd_stat) begin
      irq_stat_reg <= irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      irq_mask_reg <= FCPE_IRQ_RST;
    end else if (wr_mask) begin
      irq_mask_reg <= HWDATA_IN[FCPE_IRQ_W-1:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // read data is latched in the address phase so the data phase needs no wait
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      HRDATA_OUT <= 32'h0000_0000;
    end else if (addr_ok && !HWRITE_IN) begin
      case (HADDR_IN[7:0])
        FCPE_OFS_CTRL: begin
          HRDATA_OUT <= ctrl_word;
        end
        FCPE_OFS_IRQ_STAT: begin
          HRDATA_OUT <= 32'(irq_stat_reg);
        end
        FCPE_OFS_IRQ_MASK: begin
          HRDATA_OUT <= 32'(irq_mask_reg);
        end
        default: begin
          HRDATA_OUT <= 32'h0000_0000;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: fcpe_pkg.sv */
// constants for the flow control and power event register word
`default_nettype none
package fcpe_pkg;
  // register byte offsets
  localparam logic [7:0] FCPE_OFS_CTRL = 8'h18;
  localparam logic [7:0] FCPE_OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] FCPE_OFS_IRQ_MASK = 8'h24;
  // flow control fields of the shared word
  localparam int FCPE_BIT_PAUSED_LOW = 20;
  localparam int FCPE_BIT_PAUSED = 19;
  localparam int FCPE_BIT_FULL = 18;
  localparam int FCPE_BIT_XOFF = 17;
  localparam int FCPE_BIT_XON = 16;
  localparam int FCPE_THR_LSB = 8;
  localparam int FCPE_THR_MSB = 10;
  // power event driver flag fields
  localparam int FCPE_BIT_LINK_CHG = 31;
  localparam int FCPE_BIT_WAKE_PAT = 30;
  localparam int FCPE_BIT_INTEREST = 29;
  localparam int FCPE_BIT_RSVD28 = 28;
  localparam int FCPE_BIT_MGMT_RDY = 27;
  localparam int FCPE_BIT_MGMT_FORCE = 26;
  localparam int FCPE_BIT_MGMT_BUSY = 25;
  localparam int FCPE_BIT_WAKE_STAT = 24;
  // reset values
  localparam logic [2:0] FCPE_THR_RST = 3'h0;
  localparam logic [7:0] FCPE_PWR_FLAGS_RST = 8'h00;
  localparam logic [5:0] FCPE_IRQ_RST = 6'h00;
  // threshold steps in bytes of free receive buffer
  localparam logic [15:0] FCPE_THR_BASE0 = 16'h0200;
  localparam logic [15:0] FCPE_THR_BASE1 = 16'h0400;
  localparam logic [15:0] FCPE_THR_STEP = 16'h0100;
  // interrupt status and mask layout
  localparam int FCPE_IRQ_W = 6;
  localparam int FCPE_IRQ_LINK = 0;
  localparam int FCPE_IRQ_WAKE_PAT = 1;
  localparam int FCPE_IRQ_INTEREST = 2;
  localparam int FCPE_IRQ_WAKE = 3;
  localparam int FCPE_IRQ_PAUSED = 4;
  localparam int FCPE_IRQ_SENT = 5;
  // ahb encodings
  localparam logic [1:0] FCPE_HTRANS_NONSEQ = 2'h2;
  localparam logic FCPE_HRESP_OKAY = 1'b0;
  // flow control state machine
  typedef enum logic [1:0] {
    FCPE_FC_IDLE = 2'b00,
    FCPE_FC_REQ = 2'b01,
    FCPE_FC_FULL = 2'b10
  } fcpe_fc_state_t;
endpackage
`default_nettype wire

/* File: fcpe_chk.sv */
// assertion checker for the flow control and power event register word
`default_nettype none
module fcpe_chk
  import fcpe_pkg::*;
(
  // watched ports
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic ALT_RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic PAUSE_SEND_OUT,
  input wire logic PAUSE_SENT_IN,
  input wire logic WAKE_EVENT_IN,
  input wire logic WAKE_STATUS_OUT,
  input wire logic WAKE_EVENT_N_OUT,
  input wire logic MGMT_READY_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_IN); endclocking
  // either reset leaves some outputs undefined for the checker's purposes
  default disable iff (SYS_RST_IN || ALT_RST_IN);
  logic wr_ctrl;
  assign wr_ctrl = HSEL_IN && HREADY_IN && HTRANS_IN == FCPE_HTRANS_NONSEQ && HWRITE_IN
    && HADDR_IN[7:0] == FCPE_OFS_CTRL;
  property p_xon_rd;
    HRDATA_OUT[FCPE_BIT_XON] == 1'b0;
  endproperty
  a_xon_rd: assert property (p_xon_rd) else $error("xon bit read as one");
  property p_rsvd;
    HRDATA_OUT[23:21] == 3'h0 && HRDATA_OUT[15:11] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
  property p_ro28;
    HRDATA_OUT[FCPE_BIT_RSVD28] == 1'b0;
  endproperty
  a_ro28: assert property (p_ro28) else $error("bit 28 read as one");
  property p_mgmt;
    logic v;
    wr_ctrl ##1 (1'b1, v = HWDATA_IN[FCPE_BIT_MGMT_RDY]) |-> ##[1:2] MGMT_READY_OUT == v;
  endproperty
  a_mgmt: assert property (p_mgmt) else $error("ready output off written bit");
  property p_wake;
    WAKE_EVENT_IN |-> ##[1:2] WAKE_STATUS_OUT;
  endproperty
  a_wake: assert property (p_wake) else $error("wake event not mirrored");
  property p_wake_n;
    WAKE_STATUS_OUT |-> ##[0:1] !WAKE_EVENT_N_OUT;
  endproperty
  a_wake_n: assert property (p_wake_n) else $error("wake output not driven");
  property p_sent;
    PAUSE_SEND_OUT && PAUSE_SENT_IN |=> !PAUSE_SEND_OUT;
  endproperty
  a_sent: assert property (p_sent) else $error("pause request held after send");
  property p_rdy;
    !$past(SYS_RST_IN) |-> HREADYOUT_OUT;
  endproperty
  a_rdy: assert property (p_rdy) else $error("slave stalled");
  property p_okay;
    HRESP_OUT == FCPE_HRESP_OKAY;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  c_wake: cover property ($rose(WAKE_STATUS_OUT));
  c_sent: cover property (PAUSE_SEND_OUT && PAUSE_SENT_IN);
  c_ctrl: cover property (wr_ctrl);
endmodule
bind fcpe_flow_power_regs fcpe_chk u_chk (.*);
`default_nettype wire

/* File: fcpe_tb.sv */
// self-checking bench for the flow control and power event register word
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcpe_pkg::*;
  logic CLK_IN = 1'b0, SYS_RST_IN = 1'b1, ALT_RST_IN = 1'b1;
  logic HSEL_IN = 1'b0, HWRITE_IN = 1'b0, HREADY_IN, HREADYOUT_OUT, HRESP_OUT;
  logic [31:0] HADDR_IN = 32'h0, HWDATA_IN = 32'h0, HRDATA_OUT, q;
  logic [1:0] HTRANS_IN = 2'h0;
  logic [2:0] HSIZE_IN = 3'h2;
  logic RX_PAUSE_LOW_IN = 1'b0, LINK_UP_IN = 1'b0, MGMT_BUSY_IN = 1'b0, MGMT_FORCE_IN = 1'b0;
  logic [15:0] RX_PAUSE_VALUE_IN = 16'h0, RX_FIFO_FREE_IN = 16'hFFFF;
  logic RX_PAUSE_IN, PAUSE_TIMER_ZERO_IN, DESC_PAUSE_REQ_IN, PAUSE_SENT_IN;
  logic WAKE_PATTERN_IN, INTERESTING_FRAME_IN, WAKE_EVENT_IN;
  logic PAUSE_SEND_OUT, WAKE_STATUS_OUT, WAKE_EVENT_N_OUT, MGMT_READY_OUT, IRQ_OUT;
  logic [6:0] ev = 7'h0;
  int fail_count = 0, comparisons = 0;
  // one-cycle event strobes share a vector so a single task can pulse any mix
  assign {RX_PAUSE_IN, PAUSE_TIMER_ZERO_IN, DESC_PAUSE_REQ_IN, PAUSE_SENT_IN} = ev[6:3];
  assign {WAKE_PATTERN_IN, INTERESTING_FRAME_IN, WAKE_EVENT_IN} = ev[2:0];
  assign HREADY_IN = HREADYOUT_OUT;
  fcpe_flow_power_regs uut (.*);
  initial begin
    forever #20 CLK_IN = ~CLK_IN;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL_IN <= 1'b1;
    HTRANS_IN <= FCPE_HTRANS_NONSEQ;
    HWRITE_IN <= w;
    HADDR_IN <= {24'h0, a};
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    HSEL_IN <= 1'b0;
    HTRANS_IN <= 2'h0;
    HWDATA_IN <= d;
    do @(posedge CLK_IN); while (HREADYOUT_OUT !== 1'b1);
    q = HRDATA_OUT;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic pls(input logic [6:0] m);
    ev <= m;
    @(posedge CLK_IN);
    ev <= 7'h0;
    cyc(2);
  endtask
  task automatic t_reset;
    rdc(FCPE_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    rdc(FCPE_OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h0);
    xfer(1'b1, 8'h30, 32'hFFFFFFFF);
    rdc(8'h30, 32'hFFFFFFFF, 32'h0);
  endtask
  task automatic t_thr;
    logic [15:0] t;
    for (int k = 0; k < 8; k++) begin
      t = (k == 0) ? 16'h0200 : 16'h0400 + 16'(k - 1) * 16'h0100;
      xfer(1'b1, FCPE_OFS_CTRL, 32'h00E0F800 | (32'(k) << 8));
      rdc(FCPE_OFS_CTRL, 32'h00FFFF00, 32'(k) << 8);
      RX_FIFO_FREE_IN <= t + 16'h1;
      cyc(3);
      chk({31'h0, PAUSE_SEND_OUT}, 32'h0);
      RX_FIFO_FREE_IN <= t;
      cyc(3);
      chk({31'h0, PAUSE_SEND_OUT}, 32'h1);
      RX_FIFO_FREE_IN <= 16'hFFFF;
      cyc(3);
    end
  endtask
  task automatic t_xoff;
    xfer(1'b1, FCPE_OFS_CTRL, 32'h00020000);
    cyc(2);
    chk({31'h0, PAUSE_SEND_OUT}, 32'h1);
    rdc(FCPE_OFS_CTRL, 32'h00070000, 32'h00020000);
    pls(7'h08);
    rdc(FCPE_OFS_CTRL, 32'h00070000, 32'h00060000);
    xfer(1'b1, FCPE_OFS_CTRL, 32'h00010000);
    cyc(2);
    rdc(FCPE_OFS_CTRL, 32'h00070000, 32'h0);
    pls(7'h10);
    rdc(FCPE_OFS_CTRL, 32'h00070000, 32'h00020000);
    xfer(1'b1, FCPE_OFS_CTRL, 32'h00010000);
    cyc(2);
    rdc(FCPE_OFS_CTRL, 32'h00070000, 32'h0);
  endtask
  task automatic t_pause;
    pls(7'h40);
    rdc(FCPE_OFS_CTRL, 32'h00180000, 32'h0);
    RX_PAUSE_VALUE_IN <= 16'h0001;
    RX_PAUSE_LOW_IN <= 1'b1;
    pls(7'h40);
    rdc(FCPE_OFS_CTRL, 32'h00100000, 32'h00100000);
    RX_PAUSE_LOW_IN <= 1'b0;
    pls(7'h40);
    rdc(FCPE_OFS_CTRL, 32'h00180000, 32'h00080000);
    pls(7'h20);
    rdc(FCPE_OFS_CTRL, 32'h00180000, 32'h0);
  endtask
  task automatic t_pm;
    LINK_UP_IN <= 1'b1;
    MGMT_BUSY_IN <= 1'b1;
    MGMT_FORCE_IN <= 1'b1;
    pls(7'h07);
    cyc(3);
    chk({30'h0, WAKE_STATUS_OUT, WAKE_EVENT_N_OUT}, 32'h2);
    rdc(FCPE_OFS_CTRL, 32'hFF000000, 32'hE7000000);
    xfer(1'b1, FCPE_OFS_CTRL, 32'h08000000);
    cyc(2);
    chk({31'h0, MGMT_READY_OUT}, 32'h1);
    rdc(FCPE_OFS_CTRL, 32'hFF000000, 32'hEF000000);
    xfer(1'b1, FCPE_OFS_CTRL, 32'hFF000000);
    cyc(2);
    rdc(FCPE_OFS_CTRL, 32'hFF000000, 32'h0E000000);
    chk({30'h0, WAKE_STATUS_OUT, WAKE_EVENT_N_OUT}, 32'h1);
    MGMT_BUSY_IN <= 1'b0;
    MGMT_FORCE_IN <= 1'b0;
    cyc(4);
    rdc(FCPE_OFS_CTRL, 32'hFF000000, 32'h08000000);
  endtask
  task automatic t_irq;
    xfer(1'b0, FCPE_OFS_IRQ_STAT, 32'h0);
    pls(7'h04);
    cyc(2);
    chk({31'h0, IRQ_OUT}, 32'h0);
    xfer(1'b1, FCPE_OFS_IRQ_MASK, 32'h2);
    cyc(3);
    chk({31'h0, IRQ_OUT}, 32'h1);
    rdc(FCPE_OFS_IRQ_MASK, 32'hFFFFFFFF, 32'h2);
    rdc(FCPE_OFS_IRQ_STAT, 32'hFFFFFFFF, 32'h2);
    cyc(3);
    chk({31'h0, IRQ_OUT}, 32'h0);
  endtask
  task automatic t_alt;
    xfer(1'b1, FCPE_OFS_CTRL, 32'h08000000);
    SYS_RST_IN <= 1'b1;
    cyc(2);
    SYS_RST_IN <= 1'b0;
    cyc(1);
    rdc(FCPE_OFS_CTRL, 32'hFFFFFFFF, 32'h48000000);
    ALT_RST_IN <= 1'b1;
    cyc(2);
    ALT_RST_IN <= 1'b0;
    cyc(1);
    rdc(FCPE_OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    chk({31'h0, MGMT_READY_OUT}, 32'h0);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    cyc(20);
    SYS_RST_IN <= 1'b0;
    ALT_RST_IN <= 1'b0;
    cyc(1);
    t_reset;
    t_thr;
    t_xoff;
    t_pause;
    t_pm;
    t_irq;
    t_alt;
    print_verdict;
  end
  // whole run needs well under a thousand cycles; this catches a stuck handshake
  initial begin
    #400000;
    fail_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
